//--- design/rcac_defines.svh
// offsets, field positions and timing counts of the recorder command block
// Behaviour
// - master clock is internal 1 MHz oscillator, or dataway clock pin with jumper.
// - only commands addressed to this module's (leftmost) slot are acted upon.
// - commands are function plus subaddress; reads drive data, writes take it.
// - function 16 subaddress 0 arms and latches the 24-bit mode word.
// - function 25 subaddress 0/1/2 set end, self test, trigger; 26/0 rearms.
// - function 2 any subaddress reads memory; 16/1 writes unload enable.
// - function 0 subaddress 0/1/2 read status, post count, valid count; 6/0 id.
// - arming clears the record complete flag unless completion falls in the same cycle.
// - arming resets the memory write address to zero.
// - no digitizing happens until the module has been armed.
// - arm word bit 1 selects post-trigger (0) or pre-trigger (1) mode.
// - arm word bits 2-5 pick external clock (0) or one of fifteen rates.
// - bits 9-24 give post-trigger blocks of 16 scans; unused in post mode.
// - after the post-trigger blocks: stop, set flag, keep oldest channel-0 address.
`ifndef RCAC_DEFINES_SVH
`define RCAC_DEFINES_SVH
`define RCAC_F_READ_STATUS 5'h00
`define RCAC_F_READ_MEM 5'h02
`define RCAC_F_READ_ID 5'h06
`define RCAC_F_WRITE 5'h10
`define RCAC_F_CONTROL 5'h19
`define RCAC_F_REARM 5'h1A
`define RCAC_A_0 4'h0
`define RCAC_A_1 4'h1
`define RCAC_A_2 4'h2
`define RCAC_ARM_MODE_BIT 1
`define RCAC_ARM_CLK_LSB 2
`define RCAC_ARM_CLK_MSB 5
`define RCAC_ARM_PTC_LSB 9
`define RCAC_ARM_PTC_MSB 24
`define RCAC_ARM_RESET 24'h000000
`define RCAC_BLOCK_SHIFT 4
`define RCAC_CLK_HZ 100000000
`define RCAC_OSC_HZ 1000000
`define RCAC_OSC_DIV (`RCAC_CLK_HZ / `RCAC_OSC_HZ)
`endif

//--- design/rcac_pkg.sv
// types shared by the recorder command block
package rcac_pkg;
  typedef struct packed {
    logic n;
    logic s1;
    logic [4:0] f;
    logic [3:0] a;
    logic [24:1] w;
  } rcac_dw_in_t;

  typedef struct packed {
    logic [24:1] r;
    logic q;
    logic x;
  } rcac_dw_out_t;

  typedef enum logic [1:0] {
    RCAC_IDLE = 2'h0,
    RCAC_ARMED = 2'h1,
    RCAC_RUN = 2'h3,
    RCAC_DONE = 2'h2
  } rcac_state_t;

  typedef enum logic [3:0] {
    RCAC_CMD_NONE, RCAC_CMD_ARM, RCAC_CMD_SET_END, RCAC_CMD_SELF_TEST,
    RCAC_CMD_TRIGGER, RCAC_CMD_REARM, RCAC_CMD_READ_MEM, RCAC_CMD_UNLOAD,
    RCAC_CMD_STATUS, RCAC_CMD_POST_COUNT, RCAC_CMD_VALID_COUNT, RCAC_CMD_ID
  } rcac_cmd_t;
endpackage : rcac_pkg

//--- design/rcac_rate_div.sv
// programmable digitizing rate divider
`timescale 1ns/1ns
`default_nettype none
`include "rcac_defines.svh"
module rcac_rate_div (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_tick,
  input wire logic ext_edge,
  input wire logic [3:0] clk_code,
  input wire logic reload,
  output logic sample_tick
);
  logic [16:0] count;

  // master ticks per sample at 1 MHz for codes 1 to 15; code 0 takes external edges
  function automatic logic [16:0] divisor(input logic [3:0] code);
    case (code)
      4'h1: divisor = 17'h00004;
      4'h2: divisor = 17'h00006;
      4'h3: divisor = 17'h0000A;
      4'h4: divisor = 17'h00014;
      4'h5: divisor = 17'h00032;
      4'h6: divisor = 17'h00064;
      4'h7: divisor = 17'h000C8;
      4'h8: divisor = 17'h001F4;
      4'h9: divisor = 17'h003E8;
      4'hA: divisor = 17'h007D0;
      4'hB: divisor = 17'h01388;
      4'hC: divisor = 17'h02710;
      4'hD: divisor = 17'h04E20;
      4'hE: divisor = 17'h0C350;
      4'hF: divisor = 17'h186A0;
      default: divisor = 17'h00001;
    endcase
  endfunction : divisor

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count <= 17'h00000;
      sample_tick <= 1'b0;
    end
    else if (reload)
    begin
      count <= divisor(clk_code) - 17'h00001;
      sample_tick <= 1'b0;
    end
    else if (clk_code == 4'h0)
    begin
      sample_tick <= ext_edge;
    end
    else if (master_tick)
    begin
      // 167 kHz is approximated by a divide of six
      if (count == 17'h00000)
      begin
        count <= divisor(clk_code) - 17'h00001;
        sample_tick <= 1'b1;
      end
      else
      begin
        count <= count - 17'h00001;
        sample_tick <= 1'b0;
      end
    end
    else
    begin
      sample_tick <= 1'b0;
    end
  end
endmodule : rcac_rate_div
`default_nettype wire

//--- design/rcac_top.sv
// dataway command decoder and acquisition arming control
`timescale 1ns/1ns
`default_nettype none
`include "rcac_defines.svh"
module rcac_top #(
  parameter int ADDR_W = 20,
  // identification value is arbitrary
  parameter logic [23:0] MODULE_ID = 24'h00A5C3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rcac_pkg::rcac_dw_in_t dw_in,
  input wire logic clock_jumper_fitted,
  input wire logic dataway_clk_pin,
  input wire logic ext_clock_pin,
  input wire logic ext_trigger_pin,
  input wire logic [5:0] active_channels,
  input wire logic [23:0] mem_rd_data,
  output rcac_pkg::rcac_dw_out_t dw_out,
  output logic [ADDR_W-1:0] mem_wr_addr,
  output logic sample_strobe,
  output logic record_complete_flag,
  output logic [ADDR_W-1:0] oldest_ch0_addr,
  output logic unload_enable,
  output logic [23:0] unload_word,
  output logic self_test_start,
  output logic mem_rd_strobe
);
  rcac_pkg::rcac_dw_in_t dw_s1, dw_s2;
  logic [3:0] pin_s1, pin_s2, pin_prev;
  logic s1_prev;
  logic [6:0] osc_cnt;
  logic osc_tick, master_tick, dway_edge, ext_clk_edge, trig_edge;
  logic cmd_take, reload, sample_tick, scanning, done_evt;
  rcac_pkg::rcac_cmd_t cmd;
  rcac_pkg::rcac_state_t state, next_state;
  logic [24:1] arm_word;
  logic [ADDR_W:0] valid_cnt;
  logic [19:0] scan_cnt;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W:0] next_valid;
  logic [3:0] clk_code;

  function automatic rcac_pkg::rcac_cmd_t decode(input logic [4:0] f,
                                                 input logic [3:0] a);
    decode = rcac_pkg::RCAC_CMD_NONE;
    if (f == `RCAC_F_READ_MEM)
      decode = rcac_pkg::RCAC_CMD_READ_MEM;
    else if (f == `RCAC_F_WRITE && a == `RCAC_A_0)
      decode = rcac_pkg::RCAC_CMD_ARM;
    else if (f == `RCAC_F_WRITE && a == `RCAC_A_1)
      decode = rcac_pkg::RCAC_CMD_UNLOAD;
    else if (f == `RCAC_F_CONTROL && a == `RCAC_A_0)
      decode = rcac_pkg::RCAC_CMD_SET_END;
    else if (f == `RCAC_F_CONTROL && a == `RCAC_A_1)
      decode = rcac_pkg::RCAC_CMD_SELF_TEST;
    else if (f == `RCAC_F_CONTROL && a == `RCAC_A_2)
      decode = rcac_pkg::RCAC_CMD_TRIGGER;
    else if (f == `RCAC_F_REARM && a == `RCAC_A_0)
      decode = rcac_pkg::RCAC_CMD_REARM;
    else if (f == `RCAC_F_READ_STATUS && a == `RCAC_A_0)
      decode = rcac_pkg::RCAC_CMD_STATUS;
    else if (f == `RCAC_F_READ_STATUS && a == `RCAC_A_1)
      decode = rcac_pkg::RCAC_CMD_POST_COUNT;
    else if (f == `RCAC_F_READ_STATUS && a == `RCAC_A_2)
      decode = rcac_pkg::RCAC_CMD_VALID_COUNT;
    else if (f == `RCAC_F_READ_ID && a == `RCAC_A_0)
      decode = rcac_pkg::RCAC_CMD_ID;
  endfunction : decode

  // dataway and front panel pins are asynchronous to clk
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dw_s1 <= '0;
      dw_s2 <= '0;
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_prev <= 4'h0;
      s1_prev <= 1'b0;
    end
    else
    begin
      dw_s1 <= dw_in;
      dw_s2 <= dw_s1;
      pin_s1 <= {clock_jumper_fitted, ext_trigger_pin, ext_clock_pin,
                 dataway_clk_pin};
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
      s1_prev <= dw_s2.s1;
    end
  end

  assign dway_edge = pin_s2[0] & ~pin_prev[0];
  assign ext_clk_edge = pin_s2[1] & ~pin_prev[1];
  assign trig_edge = pin_s2[2] & ~pin_prev[2];
  // acted on once per strobe, and only when our station line is up
  assign cmd_take = dw_s2.s1 & ~s1_prev & dw_s2.n;
  assign cmd = decode(dw_s2.f, dw_s2.a);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      osc_cnt <= 7'h00;
    else if (osc_cnt == 7'(`RCAC_OSC_DIV - 1))
      osc_cnt <= 7'h00;
    else
      osc_cnt <= osc_cnt + 7'h01;
  end

  assign osc_tick = (osc_cnt == 7'(`RCAC_OSC_DIV - 1));
  assign master_tick = pin_s2[3] ? dway_edge : osc_tick;

  assign reload = cmd_take && (cmd == rcac_pkg::RCAC_CMD_ARM ||
                               cmd == rcac_pkg::RCAC_CMD_REARM);
  // a fresh arm word seeds the divider, not the word it replaces
  assign clk_code = (cmd_take && cmd == rcac_pkg::RCAC_CMD_ARM) ?
                    dw_s2.w[`RCAC_ARM_CLK_MSB:`RCAC_ARM_CLK_LSB] :
                    arm_word[`RCAC_ARM_CLK_MSB:`RCAC_ARM_CLK_LSB];

  rcac_rate_div u_rate_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .master_tick(master_tick),
    .ext_edge(ext_clk_edge),
    .clk_code(clk_code),
    .reload(reload),
    .sample_tick(sample_tick)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      arm_word <= `RCAC_ARM_RESET;
    else if (cmd_take && cmd == rcac_pkg::RCAC_CMD_ARM)
      arm_word <= dw_s2.w;
  end

  // pre-trigger mode fills memory round robin while waiting for trigger
  assign scanning = (state == rcac_pkg::RCAC_RUN) ||
                    (state == rcac_pkg::RCAC_ARMED &&
                     arm_word[`RCAC_ARM_MODE_BIT]);
  assign next_addr = mem_wr_addr + ADDR_W'(active_channels);
  assign next_valid = valid_cnt + (ADDR_W + 1)'(active_channels);

  always_comb
  begin
    next_state = state;
    done_evt = 1'b0;
    unique case (state)
      rcac_pkg::RCAC_IDLE, rcac_pkg::RCAC_DONE:
        next_state = state;
      rcac_pkg::RCAC_ARMED:
        if (trig_edge ||
            (cmd_take && cmd == rcac_pkg::RCAC_CMD_TRIGGER))
          next_state = rcac_pkg::RCAC_RUN;
      rcac_pkg::RCAC_RUN:
        if (arm_word[`RCAC_ARM_MODE_BIT])
        begin
          if (sample_tick && scan_cnt + 20'h00001 >=
              {arm_word[`RCAC_ARM_PTC_MSB:`RCAC_ARM_PTC_LSB], 4'h0})
            next_state = rcac_pkg::RCAC_DONE;
        end
        else if (sample_tick && next_valid[ADDR_W])
          next_state = rcac_pkg::RCAC_DONE;
    endcase
    if (cmd_take && cmd == rcac_pkg::RCAC_CMD_SET_END &&
        state != rcac_pkg::RCAC_IDLE)
      next_state = rcac_pkg::RCAC_DONE;
    done_evt = (next_state == rcac_pkg::RCAC_DONE) &&
               (state != rcac_pkg::RCAC_DONE);
    if (reload)
      next_state = rcac_pkg::RCAC_ARMED;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= rcac_pkg::RCAC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_wr_addr <= '0;
      valid_cnt <= '0;
      scan_cnt <= 20'h00000;
      sample_strobe <= 1'b0;
    end
    else if (reload)
    begin
      mem_wr_addr <= '0;
      valid_cnt <= '0;
      scan_cnt <= 20'h00000;
      sample_strobe <= 1'b0;
    end
    else
    begin
      sample_strobe <= sample_tick && scanning;
      if (sample_tick && scanning)
      begin
        mem_wr_addr <= next_addr;
        valid_cnt <= next_valid[ADDR_W] ? {1'b1, {ADDR_W{1'b0}}} : next_valid;
        if (state == rcac_pkg::RCAC_RUN)
          scan_cnt <= scan_cnt + 20'h00001;
      end
    end
  end

  // completion beats a same-cycle arm so no record is lost
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      record_complete_flag <= 1'b0;
      oldest_ch0_addr <= '0;
    end
    else if (done_evt)
    begin
      record_complete_flag <= 1'b1;
      oldest_ch0_addr <= (valid_cnt[ADDR_W] || next_valid[ADDR_W]) ?
                         next_addr : '0;
    end
    else if (reload)
      record_complete_flag <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      unload_enable <= 1'b0;
      unload_word <= 24'h000000;
      self_test_start <= 1'b0;
      mem_rd_strobe <= 1'b0;
    end
    else
    begin
      self_test_start <= cmd_take && cmd == rcac_pkg::RCAC_CMD_SELF_TEST;
      mem_rd_strobe <= cmd_take && cmd == rcac_pkg::RCAC_CMD_READ_MEM;
      if (reload)
        unload_enable <= 1'b0;
      else if (cmd_take && cmd == rcac_pkg::RCAC_CMD_UNLOAD)
      begin
        unload_enable <= 1'b1;
        unload_word <= dw_s2.w;
      end
    end
  end

  // read lines follow the addressed command so they settle before strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dw_out <= '0;
    else if (!dw_s2.n)
      dw_out <= '0;
    else
    begin
      dw_out.x <= 1'b1;
      dw_out.q <= (cmd != rcac_pkg::RCAC_CMD_NONE);
      case (cmd)
        rcac_pkg::RCAC_CMD_STATUS:
          dw_out.r <= {16'h0000, state, record_complete_flag,
                       arm_word[`RCAC_ARM_CLK_MSB:`RCAC_ARM_MODE_BIT]};
        rcac_pkg::RCAC_CMD_POST_COUNT:
          dw_out.r <= {8'h00,
                       arm_word[`RCAC_ARM_PTC_MSB:`RCAC_ARM_PTC_LSB]};
        rcac_pkg::RCAC_CMD_VALID_COUNT:
          dw_out.r <= 24'(valid_cnt);
        rcac_pkg::RCAC_CMD_ID:
          dw_out.r <= MODULE_ID;
        rcac_pkg::RCAC_CMD_READ_MEM:
          dw_out.r <= mem_rd_data;
        default:
          dw_out.r <= 24'h000000;
      endcase
    end
  end
endmodule : rcac_top
`default_nettype wire

//--- tb/rcac_top_monitor.sv
// port assertions for the recorder command block
`timescale 1ns/1ns
`default_nettype none
module rcac_top_monitor #(
  parameter int ADDR_W = 20,
  parameter logic [23:0] MODULE_ID = 24'h000000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rcac_pkg::rcac_dw_in_t dw_in,
  input wire rcac_pkg::rcac_dw_out_t dw_out,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic sample_strobe,
  input wire logic record_complete_flag,
  input wire logic unload_enable,
  input wire logic [23:0] unload_word,
  input wire logic self_test_start,
  input wire logic mem_rd_strobe
);
  logic s1_d;
  logic armed_once;
  // raw strobe rise; the block acts some edges later, after its sync
  wire logic rise = dw_in.s1 & ~s1_d & dw_in.n;
  wire logic [8:0] cmd = {dw_in.f, dw_in.a};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_d <= 1'b0;
      armed_once <= 1'b0;
    end
    else
    begin
      s1_d <= dw_in.s1;
      armed_once <= armed_once | (rise && cmd == 9'h100);
    end
  end
  property p_silent;
    (!dw_in.n)[*5] |-> dw_out == 26'h0;
  endproperty
  a_silent: assert property (p_silent)
    else $error("answer while not selected");
  property p_arm_flag;
    rise && cmd == 9'h100 |-> ##5 !record_complete_flag;
  endproperty
  a_arm_flag: assert property (p_arm_flag)
    else $error("arm left flag set");
  property p_arm_addr;
    rise && cmd == 9'h100 |-> ##5 mem_wr_addr == '0;
  endproperty
  a_arm_addr: assert property (p_arm_addr)
    else $error("arm left write address");
  property p_set_end;
    armed_once && rise && cmd == 9'h190 |-> ##[3:6] record_complete_flag;
  endproperty
  a_set_end: assert property (p_set_end)
    else $error("set end did not raise flag");
  property p_self_test;
    rise && cmd == 9'h191 |-> ##[3:5] self_test_start;
  endproperty
  a_self_test: assert property (p_self_test)
    else $error("self test pulse missing");
  property p_rearm;
    rise && cmd == 9'h1A0 |-> ##5 !record_complete_flag && mem_wr_addr == '0;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("rearm did not clear");
  property p_mem_read;
    rise && dw_in.f == 5'h02 |-> ##[3:5] mem_rd_strobe;
  endproperty
  a_mem_read: assert property (p_mem_read)
    else $error("memory read pulse missing");
  property p_unload;
    rise && cmd == 9'h101 |-> ##5 unload_enable && unload_word == $past(dw_in.w, 5);
  endproperty
  a_unload: assert property (p_unload)
    else $error("unload word not taken");
  property p_id;
    (dw_in.n && cmd == 9'h060)[*5] |-> dw_out.r == MODULE_ID && dw_out.q;
  endproperty
  a_id: assert property (p_id)
    else $error("wrong identification answer");
  property p_no_scan;
    !armed_once |-> !sample_strobe;
  endproperty
  a_no_scan: assert property (p_no_scan)
    else $error("scan before arm");
endmodule : rcac_top_monitor
bind rcac_top rcac_top_monitor #(.ADDR_W(ADDR_W), .MODULE_ID(MODULE_ID)) mon (
  .clk(clk), .sys_rst(sys_rst), .dw_in(dw_in), .dw_out(dw_out),
  .mem_wr_addr(mem_wr_addr), .sample_strobe(sample_strobe),
  .record_complete_flag(record_complete_flag),
  .unload_enable(unload_enable), .unload_word(unload_word),
  .self_test_start(self_test_start), .mem_rd_strobe(mem_rd_strobe));
`default_nettype wire

//--- tb/rcac_crate_ctl.sv
// crate controller model issuing one dataway command at a time
`timescale 1ns/1ns
`default_nettype none
module rcac_crate_ctl (
  input wire logic clk,
  input wire rcac_pkg::rcac_dw_out_t dw_out,
  output var rcac_pkg::rcac_dw_in_t dw_in
);
  initial
  begin
    dw_in = '0;
  end
  task automatic cmd(input logic sel, input logic [4:0] f,
    input logic [3:0] a, input logic [24:1] w,
    output rcac_pkg::rcac_dw_out_t got);
    @(negedge clk);
    dw_in.n = sel;
    dw_in.f = f;
    dw_in.a = a;
    dw_in.w = w;
    // fields settle through the sync before the strobe
    repeat (3) @(negedge clk);
    dw_in.s1 = 1'b1;
    repeat (4) @(negedge clk);
    got = dw_out;
    dw_in.s1 = 1'b0;
    // released lines must not keep their last value
    dw_in.n = 1'b0;
    dw_in.w = ~w;
    repeat (3) @(negedge clk);
  endtask : cmd
endmodule : rcac_crate_ctl
`default_nettype wire

//--- tb/rcac_top_test.sv
// self-checking bench for the recorder command block
`timescale 1ns/1ns
`default_nettype none
module rcac_top_test;
  // identification value is arbitrary
  localparam logic [23:0] ID = 24'h00A5C3;
  logic clk;
  logic sys_rst;
  logic [5:0] active_channels;
  logic [23:0] mem_rd_data;
  logic [19:0] mem_wr_addr;
  logic [19:0] a0;
  logic [19:0] oldest;
  logic jumper;
  logic [2:0] pins;
  logic sample_strobe;
  logic record_complete_flag;
  logic unload_enable;
  logic [23:0] unload_word;
  rcac_pkg::rcac_dw_in_t dw_in;
  rcac_pkg::rcac_dw_out_t dw_out;
  rcac_pkg::rcac_dw_out_t o;
  int fails;
  int comparisons;
  int n;
  rcac_crate_ctl ctl (.clk(clk), .dw_out(dw_out), .dw_in(dw_in));
  rcac_top #(.ADDR_W(20), .MODULE_ID(ID)) dut (
    .clk(clk), .sys_rst(sys_rst), .dw_in(dw_in),
    .clock_jumper_fitted(jumper), .dataway_clk_pin(pins[2]),
    .ext_clock_pin(pins[1]), .ext_trigger_pin(pins[0]),
    .active_channels(active_channels), .mem_rd_data(mem_rd_data),
    .dw_out(dw_out), .mem_wr_addr(mem_wr_addr),
    .sample_strobe(sample_strobe),
    .record_complete_flag(record_complete_flag), .oldest_ch0_addr(oldest),
    .unload_enable(unload_enable), .unload_word(unload_word),
    .self_test_start(), .mem_rd_strobe());
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // low status byte: state, flag, clock code, mode
  task automatic status(input logic [7:0] exp);
    ctl.cmd(1'b1, 5'h00, 4'h0, 24'h0, o);
    chk({18'h0, o.r[8:1]}, {18'h0, exp});
  endtask : status
  task automatic strobe_wait();
    n = 0;
    while (sample_strobe !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      fails++;
      conclude();
    end
  endtask : strobe_wait
  // pins: dataway clock, external clock, trigger; long enough for the sync
  task automatic pulse(input logic [2:0] m, input int k);
    repeat (k)
    begin
      pins = m;
      repeat (3) @(negedge clk);
      pins = 3'h0;
      repeat (3) @(negedge clk);
    end
  endtask : pulse
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    fails = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    active_channels = 6'h01;
    jumper = 1'b0;
    pins = 3'h0;
    mem_rd_data = 24'h5A1234;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    for (int c = 0; c < 16; c++)
    begin
      ctl.cmd(1'b1, 5'h10, 4'h0, {16'h1, 3'h0, 4'(c), c[0]}, o);
      status({2'h1, 1'b0, 4'(c), c[0]});
    end
    ctl.cmd(1'b1, 5'h06, 4'h0, 24'h0, o);
    chk(o, {ID, 2'h3});
    ctl.cmd(1'b1, 5'h03, 4'h0, 24'h0, o);
    chk({24'h0, o.q, o.x}, 26'h1);
    ctl.cmd(1'b0, 5'h06, 4'h0, 24'h0, o);
    chk(o, 26'h0);
    ctl.cmd(1'b1, 5'h02, 4'h7, 24'h0, o);
    chk({o.r, 2'h0}, {24'h5A1234, 2'h0});
    ctl.cmd(1'b1, 5'h10, 4'h1, 24'hC0FFEE, o);
    chk({1'b0, unload_enable, unload_word}, {2'h1, 24'hC0FFEE});
    ctl.cmd(1'b1, 5'h19, 4'h1, 24'h0, o);
    ctl.cmd(1'b1, 5'h10, 4'h0, {16'h0, 3'h0, 4'h1, 1'b0}, o);
    n = 0;
    repeat (1000)
    begin
      @(negedge clk);
      if (sample_strobe === 1'b1)
        n++;
    end
    chk(26'(n), 26'h0);
    ctl.cmd(1'b1, 5'h19, 4'h2, 24'h0, o);
    strobe_wait();
    a0 = mem_wr_addr;
    @(negedge clk);
    strobe_wait();
    chk(26'(n + 1), 26'd400);
    chk({6'h0, mem_wr_addr - a0}, 26'h1);
    ctl.cmd(1'b1, 5'h19, 4'h0, 24'h0, o);
    status({2'h2, 1'b1, 4'h1, 1'b0});
    ctl.cmd(1'b1, 5'h1A, 4'h0, 24'h0, o);
    status({2'h1, 1'b0, 4'h1, 1'b0});
    chk({6'h0, mem_wr_addr}, 26'h0);
    // zero post-trigger blocks: stops at first tick after trigger
    ctl.cmd(1'b1, 5'h10, 4'h0, {16'h0, 3'h0, 4'h1, 1'b1}, o);
    strobe_wait();
    ctl.cmd(1'b1, 5'h19, 4'h2, 24'h0, o);
    repeat (500) @(negedge clk);
    status({2'h2, 1'b1, 4'h1, 1'b1});
    // external clock, pin trigger, one block of sixteen scans
    ctl.cmd(1'b1, 5'h10, 4'h0, {16'h1, 3'h0, 4'h0, 1'b1}, o);
    pulse(3'h2, 3);
    chk({6'h0, mem_wr_addr}, 26'h3);
    pulse(3'h1, 1);
    pulse(3'h2, 15);
    status({2'h3, 1'b0, 4'h0, 1'b1});
    pulse(3'h2, 1);
    status({2'h2, 1'b1, 4'h0, 1'b1});
    chk({6'h0, oldest}, 26'h0);
    chk({6'h0, mem_wr_addr}, 26'h13);
    // master clock from the dataway pin: four edges per code 1 tick
    jumper = 1'b1;
    ctl.cmd(1'b1, 5'h10, 4'h0, {16'h0, 3'h0, 4'h1, 1'b1}, o);
    pulse(3'h4, 8);
    chk({6'h0, mem_wr_addr}, 26'h2);
    conclude();
  end
endmodule : rcac_top_test
`default_nettype wire
